// ==== common/ddc_pkg.sv ====
// Shared constants and carrier types for the down-converter stage
package ddc_pkg;
  // Datapath widths
  localparam int ADC_W   = 14;
  localparam int DATA_W  = 20;
  localparam int FREQ_W  = 32;
  localparam int ADR_W   = 8;
  localparam int ACC_W   = DATA_W + 5;
  localparam int LUT_W   = 11;
  localparam int ADC_SHIFT = DATA_W - ADC_W;

  // Register byte offsets
  localparam logic [ADR_W-1:0] REG_CTRL     = 8'h00;
  localparam logic [ADR_W-1:0] REG_FREQ     = 8'h04;
  localparam logic [ADR_W-1:0] REG_STATUS   = 8'h08;
  localparam logic [ADR_W-1:0] REG_ACT_FREQ = 8'h0C;

  // Control field positions
  localparam int CTRL_EN_BIT     = 0;
  localparam int CTRL_CPLX_BIT   = 1;
  localparam int CTRL_DSEL_LSB   = 2;
  localparam int CTRL_GAIN6_BIT  = 5;
  localparam int CTRL_GAIN3_BIT  = 6;
  localparam int CTRL_INV_BIT    = 7;
  localparam int CTRL_RELOAD_BIT = 8;
  localparam int CTRL_ALGN_BIT   = 9;
  localparam int CTRL_RES_LSB    = 10;

  // Reset values and limits
  localparam logic [31:0]       CTRL_RESET = 32'h0000_5000;
  localparam logic [FREQ_W-1:0] FREQ_RESET = 32'h0000_0000;
  localparam logic [2:0]        DSEL_MAX   = 3'h4;
  localparam logic [4:0]        RES_MIN    = 5'h0E;
  localparam logic [4:0]        RES_MAX    = 5'h14;

  // Control register layout
  typedef struct packed {
    logic [16:0] rsvd;
    logic [4:0]  out_res;
    logic        align_en;
    logic        reload;
    logic        invert;
    logic        gain3;
    logic        gain6;
    logic [2:0]  dsel;
    logic        cplx;
    logic        enable;
  } ddc_ctrl_t;

  // One I/Q sample pair
  typedef struct packed {
    logic signed [DATA_W-1:0] i;
    logic signed [DATA_W-1:0] q;
  } ddc_iq_t;
endpackage : ddc_pkg

// ==== rtl/ddc_nco.sv ====
// Phase accumulator with quarter-wave sine and cosine lookup
module ddc_nco #(
  parameter int PH_W = 32
) (
  input  wire logic                             clk,     // Sample clock
  input  wire logic                             rst,     // Synchronous reset
  input  wire logic [PH_W-1:0]                  freq,    // Active tuning word
  input  wire logic                             restart, // Clear phase
  input  wire logic                             run,     // Advance phase
  input  wire logic                             invert,  // Negative exponential
  output logic signed [ddc_pkg::LUT_W-1:0]      cos_o,   // Cosine sample
  output logic signed [ddc_pkg::LUT_W-1:0]      sin_o,   // Sine sample
  output logic [PH_W-1:0]                       phase_o  // Current phase
);
  logic [PH_W-1:0] phase_q;
  logic [1:0]      quad;
  logic [3:0]      idx;

  if (PH_W < 6) begin : g_chk
    $error("ddc_nco needs at least six phase bits");
  end

  // Quarter-wave table, entries sampled at the centre of each step
  function automatic logic signed [ddc_pkg::LUT_W-1:0] wave(input logic [1:0] q,
                                                             input logic [3:0] i);
    logic [3:0] a;
    logic [9:0] m;
    a = q[0] ? ~i : i;
    case (a)
      4'h0: m = 10'd25;   4'h1: m = 10'd75;   4'h2: m = 10'd124;  4'h3: m = 10'd172;
      4'h4: m = 10'd218;  4'h5: m = 10'd263;  4'h6: m = 10'd304;  4'h7: m = 10'd343;
      4'h8: m = 10'd379;  4'h9: m = 10'd410;  4'hA: m = 10'd438;  4'hB: m = 10'd462;
      4'hC: m = 10'd481;  4'hD: m = 10'd496;  4'hE: m = 10'd505;  default: m = 10'd510;
    endcase
    return q[1] ? -$signed({1'b0, m}) : $signed({1'b0, m});
  endfunction : wave

  assign quad    = phase_q[PH_W-1 -: 2];
  assign idx     = phase_q[PH_W-3 -: 4];
  assign phase_o = phase_q;

  // Phase advances only while mixing, which saves toggling in real mode
  always_ff @(posedge clk) begin
    if (rst || restart) begin
      phase_q <= '0;
    end else if (run) begin
      phase_q <= phase_q + freq;
    end
  end

  // Cosine leads sine by one quadrant; inversion flips the sine sign
  always_ff @(posedge clk) begin
    if (rst) begin
      cos_o <= '0;
      sin_o <= '0;
    end else begin
      cos_o <= wave(quad + 2'd1, idx);
      sin_o <= invert ? -wave(quad, idx) : wave(quad, idx);
    end
  end
endmodule : ddc_nco

// ==== rtl/ddc_top.sv ====
// Down-converter stage: mixer, low-pass decimator, gain, truncation, register slave
//
// Design decisions made here: the register offsets and the Wishbone interface to the registers.

//Contract
// - Stage bypassed until software enables it
// - Complex decimation by 2, 4, 8, 16, 32
// - Complex mode mixes samples with 32-bit oscillator
// - Real mode bypasses mixer, plain low-pass filter
// - Filter arithmetic carries 20 bits
// - Output truncated to configured resolution
// - Order: shift, low-pass at 0 Hz, decimate
// - Optional 6 dB gain in complex mode
// - Optional 3 dB gain in real mode
// - Real mode: no shift, real half only
// - Output rate equals input rate over factor
// - Frequency word is signed, covers half rate
// - New frequency active only after reload toggle; code also loads it on an alignment pin rise while align_en is set
// - Alignment resets dividers, phase, loads frequency
// - Control bit inverts mixer phase
module ddc_top (
  input  wire logic                          CLK,                    // Sample clock
  input  wire logic                          RST,                    // Sync reset, high
  input  wire logic                          WB_CYC,                 // Bus cycle
  input  wire logic                          WB_STB,                 // Bus strobe
  input  wire logic                          WB_WE,                  // Write enable
  input  wire logic [ddc_pkg::ADR_W-1:0]     WB_ADR,                 // Byte address
  input  wire logic [3:0]                    WB_SEL,                 // Byte lanes
  input  wire logic [31:0]                   WB_DAT_I,               // Write data
  output logic [31:0]                        WB_DAT_O,               // Read data
  output logic                               WB_ACK,                 // Acknowledge
  input  wire logic [ddc_pkg::ADC_W-1:0]     SAMPLE_IN,              // Converter word
  input  wire logic                          POWERDOWN_OR_ALIGN_PIN, // Alignment pin
  output ddc_pkg::ddc_iq_t                   IQ_OUT,                 // Output pair
  output logic                               OUT_VALID               // Output strobe
);
  localparam int DW = ddc_pkg::DATA_W;
  localparam int AW = ddc_pkg::ACC_W;

  ddc_pkg::ddc_ctrl_t          ctrl_q, ctrl_new;
  logic [31:0]                 freq_q, act_freq_q, wmask, rdata;
  logic                        ack_q, bus_wr, ctrl_wr, freq_wr;
  logic                        pin_s1, pin_s2, pin_s3, pin_lvl_q, pin_rise;
  logic                        align_sw, align_evt, mix_cplx;
  logic signed [DW-1:0]        smp_q, mix_i_q, mix_q_q, mix_i_d, mix_q_d;
  logic signed [ddc_pkg::LUT_W-1:0] cos_w, sin_w;
  logic signed [DW+ddc_pkg::LUT_W-1:0] prod_i, prod_q;
  logic [31:0]                 phase_w;
  logic [4:0]                  cnt_q, cnt_max;
  logic                        last_w;
  logic signed [AW-1:0]        acc_i_q, acc_q_q, sum_i, sum_q;
  logic signed [DW-1:0]        res_i_q, res_q_q, gain_i, gain_q;
  logic                        res_v_q;
  logic [DW-1:0]               tmask;
  logic [4:0]                  drop_bits;

  // Saturate a widened value back into the datapath width
  function automatic logic signed [DW-1:0] sat(input logic signed [DW+1:0] x);
    if (x > $signed({3'b000, {(DW-1){1'b1}}})) begin
      return {1'b0, {(DW-1){1'b1}}};
    end else if (x < $signed({3'b111, {(DW-1){1'b0}}})) begin
      return {1'b1, {(DW-1){1'b0}}};
    end
    return x[DW-1:0];
  endfunction : sat

  // Fixed gains: 6 dB doubles, 3 dB scales by 1.40625
  function automatic logic signed [DW-1:0] apply_gain(input logic signed [DW-1:0] v,
                                                      input logic g6, input logic g3);
    logic signed [DW+1:0] e;
    e = {{2{v[DW-1]}}, v};
    if (g6) begin
      return sat(e <<< 1);
    end else if (g3) begin
      return sat(e + (e >>> 2) + (e >>> 3) + (e >>> 5));
    end
    return v;
  endfunction : apply_gain

  // Bus decode; writes land on the edge that the master samples ack
  for (genvar b = 0; b < 4; b++) begin : g_lane
    assign wmask[8*b +: 8] = {8{WB_SEL[b]}};
  end
  assign bus_wr  = WB_CYC && WB_STB && WB_WE && ack_q;
  assign ctrl_wr = bus_wr && (WB_ADR == ddc_pkg::REG_CTRL);
  assign freq_wr = bus_wr && (WB_ADR == ddc_pkg::REG_FREQ);

  // Merge lanes, then clamp fields the datapath cannot serve
  always_comb begin
    ctrl_new = (ctrl_q & ~wmask) | (WB_DAT_I & wmask);
    ctrl_new.rsvd = '0;
    if (ctrl_new.dsel > ddc_pkg::DSEL_MAX) begin
      ctrl_new.dsel = ddc_pkg::DSEL_MAX;
    end
    if (ctrl_new.out_res < ddc_pkg::RES_MIN) begin
      ctrl_new.out_res = ddc_pkg::RES_MIN;
    end else if (ctrl_new.out_res > ddc_pkg::RES_MAX) begin
      ctrl_new.out_res = ddc_pkg::RES_MAX;
    end
  end

  // Read mux; unmapped offsets answer zero
  always_comb begin
    case (WB_ADR)
      ddc_pkg::REG_CTRL:     rdata = ctrl_q;
      ddc_pkg::REG_FREQ:     rdata = freq_q;
      ddc_pkg::REG_STATUS:   rdata = {11'h000, cnt_q, phase_w[31:16]};
      ddc_pkg::REG_ACT_FREQ: rdata = act_freq_q;
      default:               rdata = 32'h0000_0000;
    endcase
  end

  // One-cycle acknowledge, dropped after each answer
  always_ff @(posedge CLK) begin
    if (RST) begin
      ack_q    <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
    end else begin
      ack_q    <= WB_CYC && WB_STB && !ack_q;
      WB_DAT_O <= (WB_CYC && WB_STB && !ack_q) ? rdata : 32'h0000_0000;
    end
  end
  assign WB_ACK = ack_q;

  // Control and pending tuning word
  always_ff @(posedge CLK) begin
    if (RST) begin
      ctrl_q <= ddc_pkg::CTRL_RESET;
      freq_q <= ddc_pkg::FREQ_RESET;
    end else begin
      if (ctrl_wr) begin
        ctrl_q <= ctrl_new;
      end
      if (freq_wr) begin
        freq_q <= (freq_q & ~wmask) | (WB_DAT_I & wmask);
      end
    end
  end

  // Pin alignment: three stages, change counted when stages two and three agree
  always_ff @(posedge CLK) begin
    if (RST) begin
      pin_s1    <= 1'b0;
      pin_s2    <= 1'b0;
      pin_s3    <= 1'b0;
      pin_lvl_q <= 1'b0;
    end else begin
      pin_s1    <= POWERDOWN_OR_ALIGN_PIN;
      pin_s2    <= pin_s1;
      pin_s3    <= pin_s2;
      pin_lvl_q <= (pin_s2 == pin_s3) ? pin_s3 : pin_lvl_q;
    end
  end
  assign pin_rise  = (pin_s2 == pin_s3) && pin_s3 && !pin_lvl_q && ctrl_q.align_en;
  assign align_sw  = ctrl_wr && (ctrl_new.reload != ctrl_q.reload);
  assign align_evt = align_sw || pin_rise;

  // Tuning word only moves into the oscillator on alignment
  always_ff @(posedge CLK) begin
    if (RST) begin
      act_freq_q <= ddc_pkg::FREQ_RESET;
    end else if (align_evt) begin
      act_freq_q <= freq_q;
    end
  end

  assign mix_cplx = ctrl_q.enable && ctrl_q.cplx;

  // Signed tuning word wraps the phase, covering minus to plus half rate
  ddc_nco #(
    .PH_W    (ddc_pkg::FREQ_W)
  ) u_nco (
    .clk     (CLK),
    .rst     (RST),
    .freq    (act_freq_q),
    .restart (align_evt),
    .run     (mix_cplx),
    .invert  (ctrl_q.invert),
    .cos_o   (cos_w),
    .sin_o   (sin_w),
    .phase_o (phase_w)
  );

  // Mixer: complex shift first, real path passes the sample untouched
  assign prod_i  = smp_q * cos_w;
  assign prod_q  = smp_q * sin_w;
  assign mix_i_d = mix_cplx ? prod_i[DW+8:9] : smp_q;
  assign mix_q_d = mix_cplx ? prod_q[DW+8:9] : '0;

  // Sample widened to the 20-bit datapath on entry
  always_ff @(posedge CLK) begin
    if (RST) begin
      smp_q   <= '0;
      mix_i_q <= '0;
      mix_q_q <= '0;
    end else begin
      smp_q   <= {SAMPLE_IN, {ddc_pkg::ADC_SHIFT{1'b0}}};
      mix_i_q <= mix_i_d;
      mix_q_q <= mix_q_d;
    end
  end

  // Boxcar integrate-and-dump: low-pass at 0 Hz, then one output per N inputs
  assign cnt_max = (5'h02 << ctrl_q.dsel) - 5'h01;
  // At or above the limit, so a shorter factor written without alignment still ends the frame
  assign last_w  = (cnt_q >= cnt_max);
  assign sum_i   = acc_i_q + AW'(mix_i_q);
  assign sum_q   = acc_q_q + AW'(mix_q_q);

  // Accumulator growth absorbs N; divide by shift keeps 20 bits
  always_ff @(posedge CLK) begin
    if (RST || align_evt || !ctrl_q.enable) begin
      cnt_q   <= 5'h00;
      acc_i_q <= '0;
      acc_q_q <= '0;
    end else if (last_w) begin
      cnt_q   <= 5'h00;
      acc_i_q <= '0;
      acc_q_q <= '0;
    end else begin
      cnt_q   <= cnt_q + 5'h01;
      acc_i_q <= sum_i;
      acc_q_q <= sum_q;
    end
  end

  // Decimated result; bypass forwards every sample
  always_ff @(posedge CLK) begin
    if (RST) begin
      res_i_q <= '0;
      res_q_q <= '0;
      res_v_q <= 1'b0;
    end else if (!ctrl_q.enable) begin
      res_i_q <= mix_i_q;
      res_q_q <= '0;
      res_v_q <= 1'b1;
    end else begin
      res_i_q <= DW'(sum_i >>> (ctrl_q.dsel + 3'h1));
      res_q_q <= DW'(sum_q >>> (ctrl_q.dsel + 3'h1));
      res_v_q <= last_w && !align_evt;
    end
  end

  // Gain per mode, then truncation to the chosen resolution
  assign gain_i    = ctrl_q.enable ? apply_gain(res_i_q, mix_cplx && ctrl_q.gain6,
                                                !ctrl_q.cplx && ctrl_q.gain3) : res_i_q;
  assign gain_q    = ctrl_q.enable ? apply_gain(res_q_q, mix_cplx && ctrl_q.gain6,
                                                !ctrl_q.cplx && ctrl_q.gain3) : res_q_q;
  assign drop_bits = ddc_pkg::RES_MAX - ctrl_q.out_res;
  assign tmask     = {DW{1'b1}} << drop_bits;

  // I and Q leave together with the strobe
  always_ff @(posedge CLK) begin
    if (RST) begin
      IQ_OUT    <= '0;
      OUT_VALID <= 1'b0;
    end else begin
      OUT_VALID <= res_v_q;
      if (res_v_q) begin
        IQ_OUT.i <= gain_i & tmask;
        IQ_OUT.q <= gain_q & tmask;
      end
    end
  end

  // Checks
  a_bypass_every_cycle: assert property (@(posedge CLK) disable iff (RST)
    !RST && !ctrl_q.enable ##1 !ctrl_q.enable |=> OUT_VALID)
    else $error("bypass did not stream every cycle");
  a_decim_two_spacing: assert property (@(posedge CLK)
    disable iff (RST || align_evt || ctrl_wr)
    res_v_q && ctrl_q.enable && ctrl_q.dsel == 3'h0 && !align_evt && !ctrl_wr
      |=> !res_v_q ##1 res_v_q)
    else $error("decimate by two spacing wrong");
  a_decim_four_spacing: assert property (@(posedge CLK)
    disable iff (RST || align_evt || ctrl_wr)
    res_v_q && ctrl_q.enable && ctrl_q.dsel == 3'h1 && !align_evt && !ctrl_wr
      |=> !res_v_q [*3] ##1 res_v_q)
    else $error("decimate by four spacing wrong");
  a_align_resets_state: assert property (@(posedge CLK) disable iff (RST)
    align_evt |=> cnt_q == 5'h00 && phase_w == 32'h0000_0000 && act_freq_q == $past(freq_q))
    else $error("alignment did not reset dividers and phase");
  a_freq_held_idle: assert property (@(posedge CLK) disable iff (RST)
    !align_evt |=> $stable(act_freq_q))
    else $error("tuning word changed without alignment");
  a_real_no_quad: assert property (@(posedge CLK) disable iff (RST)
    !mix_cplx |=> mix_q_q == '0 && mix_i_q == $past(smp_q))
    else $error("real path was mixed");
  a_trunc_low_bits: assert property (@(posedge CLK) disable iff (RST)
    res_v_q && ctrl_q.out_res == 5'h0E |=> IQ_OUT.i[5:0] == 6'h00 && IQ_OUT.q[5:0] == 6'h00)
    else $error("low bits not truncated");
  a_gain_saturates: assert property (@(posedge CLK) disable iff (RST)
    res_v_q && mix_cplx && ctrl_q.gain6 && ctrl_q.out_res == 5'h14
      && res_i_q > $signed(20'h4_0000) |=> IQ_OUT.i == 20'h7_FFFF)
    else $error("gain wrapped instead of saturating");
  a_ack_one_cycle: assert property (@(posedge CLK) disable iff (RST)
    WB_CYC && WB_STB && !WB_ACK |=> WB_ACK ##1 !WB_ACK)
    else $error("bus acknowledge timing wrong");
endmodule : ddc_top

// ==== tb/ddc_sink.sv ====
// Downstream capture model that measures the spacing of output strobes
module ddc_sink (
  input  wire logic        clk,   // Sample clock
  input  wire logic        rst,   // Sync reset, high
  input  wire logic        valid, // Output strobe
  output logic      [7:0]  gap,   // Cycles since previous strobe
  output logic      [15:0] seen   // Strobes captured
);
  logic [7:0] cnt_q;

  // Combinational so the monitor reads it at the strobe edge itself
  assign gap = cnt_q + 8'h01;

  // Capture never stalls; the stream has no back-pressure to offer
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= 8'h00;
      seen  <= 16'h0000;
    end else if (valid) begin
      cnt_q <= 8'h00;
      seen  <= seen + 16'h0001;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
endmodule : ddc_sink

// ==== tb/tb_ddc_top.sv ====
// Self-checking bench for the down-converter stage
module tb_ddc_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    ddc_pkg::ddc_iq_t iq;
    logic [7:0]       gap;
  } ddc_note_t;
  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] freq;
    logic [13:0] x;
    logic [19:0] ei;
    logic [19:0] eq;
  } ddc_case_t;

  logic             CLK, RST, WB_CYC, WB_STB, WB_WE, WB_ACK, OUT_VALID;
  logic             POWERDOWN_OR_ALIGN_PIN, rl;
  logic [7:0]       WB_ADR, gap;
  logic [3:0]       WB_SEL;
  logic [31:0]      WB_DAT_I, WB_DAT_O, rd, seed;
  logic [13:0]      SAMPLE_IN, xx;
  logic signed [31:0] t, u;
  ddc_pkg::ddc_iq_t IQ_OUT;
  ddc_note_t        notes[$];
  ddc_note_t        nt;
  ddc_case_t        cases[10];
  int               num_errors, n_tests, cycles;

  ddc_top DUT (.CLK, .RST, .WB_CYC, .WB_STB, .WB_WE, .WB_ADR, .WB_SEL, .WB_DAT_I,
    .WB_DAT_O, .WB_ACK, .SAMPLE_IN, .POWERDOWN_OR_ALIGN_PIN, .IQ_OUT, .OUT_VALID);
  ddc_sink u_sink (.clk(CLK), .rst(RST), .valid(OUT_VALID), .gap(gap), .seen());

  // 200 MHz sample clock
  initial begin
    CLK = 1'b0;
    forever #2.5 CLK = ~CLK;
  end

  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wrap_up();
    if (num_errors == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : wrap_up

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    xs = v ^ (v << 5);
  endfunction : xs

  function automatic logic [31:0] ctl(input int cp, input int d, input int g6, input int g3,
                                      input int res);
    ctl = {17'h0_0000, res[4:0], 3'h0, g3[0], g6[0], d[2:0], cp[0], 1'b1};
  endfunction : ctl

  // Classic single cycle: hold until ack is sampled, then idle one cycle
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                    input logic [3:0] sel);
    @(posedge CLK);
    WB_CYC   <= 1'b1;
    WB_STB   <= 1'b1;
    WB_WE    <= we;
    WB_ADR   <= adr;
    WB_SEL   <= sel;
    WB_DAT_I <= dat;
    do @(posedge CLK); while (WB_ACK !== 1'b1);
    rd = WB_DAT_O;
    WB_CYC <= 1'b0;
    WB_STB <= 1'b0;
    WB_WE  <= 1'b0;
    @(posedge CLK);
  endtask : wb

  // Configure, let the divider settle, then expect three regular outputs
  task automatic run(input ddc_case_t c);
    ddc_note_t n;
    SAMPLE_IN <= c.x;
    wb(1'b1, ddc_pkg::REG_FREQ, c.freq, 4'hF);
    rl = ~rl;
    wb(1'b1, ddc_pkg::REG_CTRL, c.ctrl | {23'h00_0000, rl, 8'h00}, 4'hF);
    repeat (80) @(posedge CLK);
    n.iq.i = c.ei;
    n.iq.q = c.eq;
    n.gap  = c.ctrl[0] ? (8'h02 << c.ctrl[4:2]) : 8'h01;
    repeat (3) notes.push_back(n);
    while (notes.size() > 0) @(posedge CLK);
  endtask : run

  // Monitor: each strobe consumes the oldest note
  always @(posedge CLK) begin
    if (OUT_VALID === 1'b1 && notes.size() > 0) begin
      nt = notes.pop_front();
      check({IQ_OUT, gap}, nt);
    end
  end

  // Hang guard; the whole run needs a few thousand cycles
  always @(posedge CLK) begin
    cycles++;
    if (cycles > 30000) begin
      num_errors++;
      wrap_up();
    end
  end

  initial begin
    {WB_CYC, WB_STB, WB_WE, POWERDOWN_OR_ALIGN_PIN, rl} = '0;
    WB_ADR = '0;
    WB_SEL = '0;
    WB_DAT_I = '0;
    SAMPLE_IN = '0;
    seed = 32'h0000_0050;
    RST = 1'b1;
    repeat (10) @(posedge CLK);
    RST <= 1'b0;
    wb(1'b0, ddc_pkg::REG_CTRL, '0, 4'hF);
    check(rd, ddc_pkg::CTRL_RESET);
    wb(1'b0, 8'h40, '0, 4'hF);
    check(rd, '0);
    // Lane mask, then pending word stays inactive until a reload toggle
    wb(1'b1, ddc_pkg::REG_FREQ, 32'hFFFF_FFFF, 4'h3);
    wb(1'b0, ddc_pkg::REG_FREQ, '0, 4'hF);
    check(rd, 32'h0000_FFFF);
    wb(1'b0, ddc_pkg::REG_ACT_FREQ, '0, 4'hF);
    check(rd, '0);
    rl = 1'b1;
    wb(1'b1, ddc_pkg::REG_CTRL, ddc_pkg::CTRL_RESET | 32'h0000_0100, 4'hF);
    wb(1'b0, ddc_pkg::REG_ACT_FREQ, '0, 4'hF);
    check(rd, 32'h0000_FFFF);
    // Alignment pin loads the pending word when allowed
    wb(1'b1, ddc_pkg::REG_CTRL, ddc_pkg::CTRL_RESET | 32'h0000_0300, 4'hF);
    wb(1'b1, ddc_pkg::REG_FREQ, 32'h0BAD_0001, 4'hF);
    POWERDOWN_OR_ALIGN_PIN <= 1'b1;
    repeat (8) @(posedge CLK);
    POWERDOWN_OR_ALIGN_PIN <= 1'b0;
    wb(1'b0, ddc_pkg::REG_ACT_FREQ, '0, 4'hF);
    check(rd, 32'h0BAD_0001);
    wb(1'b1, ddc_pkg::REG_CTRL, ctl(1'b0, 3'h7, 1'b0, 1'b0, 5'h14), 4'hF);
    rl = 1'b0;
    wb(1'b0, ddc_pkg::REG_CTRL, '0, 4'hF);
    check(rd[4:2], 3'h4);
    // Bypass streams every cycle with random words
    repeat (2) begin
      seed = xs(seed);
      run('{ddc_pkg::CTRL_RESET, 32'h0, seed[13:0], {seed[13:0], 6'h00}, 20'h0});
    end
    // Fixed cases: gains, saturation, truncation, mixing, real path
    cases[0] = '{ctl(0, 0, 0, 1, 20), 32'h0, 14'h1F40, 20'h7_FFFF, 20'h0};
    cases[1] = '{ctl(0, 0, 0, 1, 20), 32'h0, 14'h20C0, 20'h8_0000, 20'h0};
    cases[2] = '{ctl(0, 2, 0, 1, 14), 32'h0, 14'h0065, 20'h0_2380, 20'h0};
    cases[3] = '{ctl(0, 1, 1, 0, 20), 32'h0, 14'h0065, 20'h0_1940, 20'h0};
    cases[4] = '{ctl(1, 0, 0, 0, 20), 32'h0, 14'h0320, 20'h0_C738, 20'h0_09C4};
    cases[5] = '{ctl(1, 0, 1, 0, 20), 32'h0, 14'h0320, 20'h1_8E70, 20'h0_1388};
    cases[6] = '{ctl(1, 1, 0, 0, 20), 32'h4000_0000, 14'h0320, 20'h0_0000, 20'h0};
    cases[7] = '{ctl(0, 1, 0, 0, 20), 32'h4000_0000, 14'h0320, 20'h0_C800, 20'h0};
    cases[8] = '{ctl(1, 0, 1, 0, 20), 32'h0, 14'h1F40, 20'h7_FFFF, 20'h0_C350};
    cases[9] = '{ctl(1, 0, 0, 0, 20) | 32'h80, 32'h0, 14'h0320, 20'h0_C738, 20'hF_F63C};
    foreach (cases[k]) run(cases[k]);
    // Every complex factor with random words at zero tuning
    for (int d = 0; d < 5; d++) begin
      seed = xs(seed);
      xx = {seed[13:3], 3'h0};
      t = $signed(xx) * 255 / 4;
      u = $signed(xx) * 25 / 8;
      run('{ctl(1, d, 0, 0, 20), 32'h0, xx, t[19:0], u[19:0]});
    end
    wrap_up();
  end
endmodule : tb_ddc_top
